// *** rtl/dst_top.v ***
// Drive start sequencer for four axes: write strobe to busy, then timed
// start of status, direction and pulse outputs per command kind.
// Assumes write_strobe_n_i comes from an asynchronous host bus.
`timescale 1ns/1ps
`include "dst_consts.vh"
module dst_top #(
	parameter NUM_AXES = `DST_NUM_AXES,
	parameter RATE_W   = 24,
	parameter CNT_W    = 32
) (
	// Clock and reset
	input  wire                   core_clk_i,
	input  wire                   rst_i,
	// Host command port
	input  wire                   write_strobe_n_i,
	input  wire [1:0]             cmd_i,
	input  wire [NUM_AXES-1:0]    axis_sel_i,
	input  wire [NUM_AXES-1:0]    dir_i,
	input  wire                   two_pulse_i,
	input  wire                   continuous_i,
	input  wire [1:0]             profile_i,
	input  wire [RATE_W-1:0]      rate_max_i,
	input  wire [RATE_W-1:0]      rate_init_i,
	input  wire [RATE_W-1:0]      accel_i,
	input  wire [CNT_W-1:0]       pulse_count_i,
	output reg                    write_busy_n_o,
	// Motor pins
	output wire [NUM_AXES-1:0]    plus_pulse_out_o,
	output wire [NUM_AXES-1:0]    minus_pulse_out_o,
	output wire [NUM_AXES-1:0]    drive_pulse_out_o,
	output wire [NUM_AXES-1:0]    direction_out_o,
	output reg  [NUM_AXES-1:0]    driving_status_out_o
);
	// Rate step per pulse/s: 2^26 / 100e6; the 2^26 scale keeps the 8 Mpps step inside 24 bits
	localparam [RATE_W-1:0] RATE_FULL = 24'h51EB85; // 8 Mpps
	localparam [RATE_W-1:0] RATE_CONT = 24'h28F5C2; // 4 Mpps
	localparam [RATE_W-1:0] RATE_MIN  = 24'h000002; // lowest step not below 2 pps
	localparam [1:0]        BUSY_LAST = `DST_BUSY_CYC - 1;
	localparam ST_IDLE  = 2'h0;
	localparam ST_BUSY  = 2'h1;
	localparam ST_DELAY = 2'h2;

	reg                 wr_meta_r;
	reg                 wr_sync_r;
	reg                 wr_prev_r;
	reg  [1:0]          state_r;
	reg  [1:0]          busy_cnt_r;
	reg  [2:0]          dly_r;
	reg  [1:0]          cmd_r;
	reg  [NUM_AXES-1:0] sel_r;
	reg  [NUM_AXES-1:0] held_r;
	reg  [NUM_AXES-1:0] start_r;
	reg  [NUM_AXES-1:0] stop_r;
	reg                 interp_r;
	wire [NUM_AXES-1:0] done;
	wire                wr_rise = wr_sync_r & ~wr_prev_r;
	wire [RATE_W-1:0]   cap = (interp_r && continuous_i) ? RATE_CONT : RATE_FULL;
	wire [RATE_W-1:0]   rate_lim = (rate_max_i > cap) ? cap : ((rate_max_i < RATE_MIN) ? RATE_MIN : rate_max_i);
	// Interpolated axes share one pulse timebase by gating the accumulators together
	wire                interp_en = interp_r ? &(done | ~sel_r) == 1'b0 : 1'b1;

	// Strobe is asynchronous to the core clock
	always @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			wr_meta_r <= 1'b1;
			wr_sync_r <= 1'b1;
			wr_prev_r <= 1'b1;
		end
		else
		begin
			wr_meta_r <= write_strobe_n_i;
			wr_sync_r <= wr_meta_r;
			wr_prev_r <= wr_sync_r;
		end
	end

	// Only this command interface starts motion or stops it early; otherwise an axis stops at the end of its count
	always @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			state_r              <= ST_IDLE;
			busy_cnt_r           <= 2'h0;
			dly_r                <= 3'h0;
			cmd_r                <= `DST_CMD_DRIVE;
			sel_r                <= {NUM_AXES{1'b0}};
			held_r               <= {NUM_AXES{1'b0}};
			start_r              <= {NUM_AXES{1'b0}};
			stop_r               <= {NUM_AXES{1'b0}};
			interp_r             <= 1'b0;
			write_busy_n_o       <= 1'b1;
			driving_status_out_o <= {NUM_AXES{1'b0}};
		end
		else
		begin
			start_r <= {NUM_AXES{1'b0}};
			stop_r  <= {NUM_AXES{1'b0}};
			// Clear only when idle, so the latency cycles cannot drop a freshly raised status
			if (state_r == ST_IDLE)
				driving_status_out_o <= driving_status_out_o & ~(done & ~start_r & ~held_r);
			case (state_r)
			ST_IDLE:
				if (wr_rise)
				begin
					cmd_r          <= cmd_i;
					sel_r          <= axis_sel_i;
					write_busy_n_o <= 1'b0;
					busy_cnt_r     <= BUSY_LAST;
					state_r        <= ST_BUSY;
				end
			ST_BUSY:
				if (busy_cnt_r == 2'h0)
				begin
					write_busy_n_o <= 1'b1;
					state_r        <= ST_DELAY;
					dly_r          <= 3'h1;
					interp_r       <= (cmd_r == `DST_CMD_INTERP);
					// Held start: status rises together with busy
					if (cmd_r == `DST_CMD_HOLD_REL)
						driving_status_out_o <= driving_status_out_o | held_r;
					else if (cmd_r == `DST_CMD_DRIVE)
						// Parked axes stay quiet until their release
						driving_status_out_o <= driving_status_out_o | (sel_r & ~held_r);
					else if (cmd_r == `DST_CMD_STOP)
					begin
						stop_r  <= sel_r;
						held_r  <= held_r & ~sel_r;
						state_r <= ST_IDLE;
					end
				end
				else
					busy_cnt_r <= busy_cnt_r - 2'h1;
			ST_DELAY:
			begin
				dly_r <= dly_r + 3'h1;
				if (cmd_r == `DST_CMD_INTERP && dly_r == `DST_INTERP_DRV_DLY)
					driving_status_out_o <= driving_status_out_o | sel_r;
				// Start register and axis each add a cycle before the pins, so launch two early
				if (cmd_r == `DST_CMD_INTERP && dly_r == `DST_INTERP_PULSE_DLY - 2)
				begin
					start_r <= sel_r;
					state_r <= ST_IDLE;
				end
				else if (cmd_r == `DST_CMD_HOLD_REL && dly_r == `DST_HOLD_PULSE_DLY - 2)
				begin
					start_r <= held_r;
					held_r  <= {NUM_AXES{1'b0}};
					state_r <= ST_IDLE;
				end
				else if (cmd_r == `DST_CMD_DRIVE && dly_r == `DST_HOLD_PULSE_DLY - 2)
				begin
					// A plain drive with hold set is parked until release
					start_r <= sel_r & ~held_r;
					state_r <= ST_IDLE;
				end
				else if (dly_r == 3'h7)
					state_r <= ST_IDLE;
			end
			default:
				state_r <= ST_IDLE;
			endcase
			if (state_r == ST_IDLE && wr_rise && cmd_i == `DST_CMD_DRIVE && continuous_i)
				held_r <= held_r | axis_sel_i;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_AXES; g = g + 1)
		begin : g_axis
			// Identical channels
			dst_axis #(
				.RATE_W (RATE_W),
				.CNT_W  (CNT_W)
			) u_axis (
				.core_clk_i        (core_clk_i),
				.rst_i             (rst_i),
				.start_i           (start_r[g]),
				.stop_i            (stop_r[g]),
				.pulse_en_i        (interp_en),
				.two_pulse_i       (two_pulse_i),
				.dir_i             (dir_i[g]),
				.profile_i         (profile_i),
				.rate_max_i        (rate_lim),
				.rate_init_i       (rate_init_i),
				.accel_i           (accel_i),
				.pulse_count_i     (pulse_count_i),
				.plus_pulse_out_o  (plus_pulse_out_o[g]),
				.minus_pulse_out_o (minus_pulse_out_o[g]),
				.drive_pulse_out_o (drive_pulse_out_o[g]),
				.direction_out_o   (direction_out_o[g]),
				.done_o            (done[g])
			);
		end
	endgenerate
endmodule // dst_top

// *** rtl/dst_consts.vh ***
// Constants for the drive start timing block: latencies counted from the
// rising edge of write_busy_n, pulse-rate limits, command codes and speed profiles.
// Assumes a single 100 MHz core clock; the busy and latency figures are in core clock cycles.
`ifndef DST_CONSTS_VH
`define DST_CONSTS_VH
`define DST_CLK_HZ          100000000
`define DST_NUM_AXES        4
`define DST_BUSY_CYC        2
`define DST_INTERP_PULSE_DLY 4
`define DST_INTERP_DRV_DLY  1
`define DST_HOLD_PULSE_DLY  3
`define DST_MAX_RATE_PPS    8000000
`define DST_CONT_RATE_PPS   4000000
`define DST_MIN_RATE_PPS    2
`define DST_CMD_DRIVE       2'h0
`define DST_CMD_INTERP      2'h1
`define DST_CMD_HOLD_REL    2'h2
`define DST_CMD_STOP        2'h3
`define DST_PROF_CONST      2'h0
`define DST_PROF_TRAP       2'h1
`define DST_PROF_SCURVE     2'h2
`endif

// *** rtl/dst_axis.v ***
// One axis channel: rate accumulator, speed profile and pulse/direction shaping.
// Assumes start/stop pulses and the rate step come from the same core clock.
`timescale 1ns/1ps
`include "dst_consts.vh"
module dst_axis #(
	parameter RATE_W = 24,
	parameter CNT_W  = 32
) (
	// Clock and reset
	input  wire              core_clk_i,
	input  wire              rst_i,
	// Control from the sequencer
	input  wire              start_i,
	input  wire              stop_i,
	input  wire              pulse_en_i,
	input  wire              two_pulse_i,
	input  wire              dir_i,
	input  wire [1:0]        profile_i,
	input  wire [RATE_W-1:0] rate_max_i,
	input  wire [RATE_W-1:0] rate_init_i,
	input  wire [RATE_W-1:0] accel_i,
	input  wire [CNT_W-1:0]  pulse_count_i,
	// Motor pins
	output reg               plus_pulse_out_o,
	output reg               minus_pulse_out_o,
	output reg               drive_pulse_out_o,
	output reg               direction_out_o,
	output wire              done_o
);
	// Phase accumulator width gives resolution of clock/2^ACC_W per step
	localparam ACC_W = 26;
	reg [ACC_W-1:0]  phase_r;
	reg [RATE_W-1:0] rate_r;
	reg [RATE_W-1:0] jerk_r;
	reg [CNT_W-1:0]  left_r;
	reg              run_r;
	reg              hi_r;
	reg              guard_r;
	wire [ACC_W:0]   phase_sum = {1'b0, phase_r} + {{(ACC_W-RATE_W+1){1'b0}}, rate_r};
	wire             tick = phase_sum[ACC_W];
	wire             decel = (left_r <= {{(CNT_W-RATE_W+8){1'b0}}, rate_r[RATE_W-1:8]});

	assign done_o = ~run_r;

	always @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			phase_r           <= {ACC_W{1'b0}};
			rate_r            <= {RATE_W{1'b0}};
			jerk_r            <= {RATE_W{1'b0}};
			left_r            <= {CNT_W{1'b0}};
			run_r             <= 1'b0;
			hi_r              <= 1'b0;
			guard_r           <= 1'b0;
			plus_pulse_out_o  <= 1'b0;
			minus_pulse_out_o <= 1'b0;
			drive_pulse_out_o <= 1'b0;
			direction_out_o   <= 1'b0;
		end
		else
		begin
			if (start_i)
			begin
				run_r   <= 1'b1;
				// First pulse leaves at once, so the start latency does not depend on the rate
				hi_r    <= |pulse_count_i;
				left_r  <= pulse_count_i - {{(CNT_W-1){1'b0}}, |pulse_count_i};
				rate_r  <= (profile_i == `DST_PROF_CONST) ? rate_max_i : rate_init_i;
				jerk_r  <= {RATE_W{1'b0}};
				phase_r <= {ACC_W{1'b0}};
				// Direction pin changes one cycle ahead of the first pulse pin
				direction_out_o <= dir_i;
			end
			else if (stop_i || (run_r && left_r == {CNT_W{1'b0}} && !hi_r))
				run_r <= 1'b0;
			else if (run_r && pulse_en_i)
			begin
				phase_r <= phase_sum[ACC_W-1:0];
				if (tick && !hi_r && !guard_r)
				begin
					// High phase for one cycle; guard cycle after keeps direction stable
					hi_r   <= 1'b1;
					left_r <= left_r - {{(CNT_W-1){1'b0}}, 1'b1};
					// Profile update once per output pulse
					if (profile_i == `DST_PROF_TRAP)
						rate_r <= decel ? ((rate_r > rate_init_i + accel_i) ? rate_r - accel_i : rate_init_i)
							: ((rate_r + accel_i < rate_max_i) ? rate_r + accel_i : rate_max_i);
					else if (profile_i == `DST_PROF_SCURVE)
					begin
						jerk_r <= decel ? ((jerk_r > accel_i) ? jerk_r - accel_i : {RATE_W{1'b0}})
							: ((jerk_r < accel_i) ? jerk_r + {{(RATE_W-1){1'b0}}, 1'b1} : jerk_r);
						rate_r <= decel ? ((rate_r > rate_init_i + jerk_r) ? rate_r - jerk_r : rate_init_i)
							: ((rate_r + jerk_r < rate_max_i) ? rate_r + jerk_r : rate_max_i);
					end
				end
			end
			if (hi_r)
			begin
				hi_r    <= 1'b0;
				guard_r <= 1'b1;
			end
			else
				guard_r <= 1'b0;
			// Registered pins change only on the rising edge
			drive_pulse_out_o <= hi_r;
			plus_pulse_out_o  <= hi_r & (two_pulse_i ? ~direction_out_o : 1'b1) & two_pulse_i;
			minus_pulse_out_o <= hi_r & two_pulse_i & direction_out_o;
		end
	end
endmodule // dst_axis

// *** verif/dst_chk_assertions.sv ***
// Checker for dst_top: busy width, start latencies, direction hold, rate limits.
// Assumes cmd_i, axis_sel_i and continuous_i stay put for a whole sequence.
`timescale 1ns/1ps
`include "dst_consts.vh"
module dst_chk #(
	parameter NUM_AXES = 4
) (
	// Clock, reset and host side
	input wire			core_clk_i,
	input wire			rst_i,
	input wire [1:0]		cmd_i,
	input wire [NUM_AXES-1:0]	axis_sel_i,
	input wire			two_pulse_i,
	input wire			continuous_i,
	input wire			write_busy_n_o,
	// Motor pins
	input wire [NUM_AXES-1:0]	plus_pulse_out_o,
	input wire [NUM_AXES-1:0]	minus_pulse_out_o,
	input wire [NUM_AXES-1:0]	drive_pulse_out_o,
	input wire [NUM_AXES-1:0]	direction_out_o,
	input wire [NUM_AXES-1:0]	driving_status_out_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	wire [NUM_AXES-1:0]	pl = plus_pulse_out_o | minus_pulse_out_o | drive_pulse_out_o;
	reg			busy_q_r;
	wire			b_up = write_busy_n_o & ~busy_q_r;
	// Busy as seen one edge earlier, so b_up marks the edge where busy has just returned high
	always @(posedge core_clk_i)
		busy_q_r <= rst_i ? 1'b1 : write_busy_n_o;
	// Gap since the last axis 0 pulse; a new command restarts it so the first pulse is free
	reg [7:0]		gap_r;
	always @(posedge core_clk_i)
		if (rst_i || !write_busy_n_o)
			gap_r <= 8'hFF;
		else if (pl[0])
			gap_r <= 8'h00;
		else if (gap_r != 8'hFF)
			gap_r <= gap_r + 8'h01;
	property p_busy; $fell(write_busy_n_o) |=> !write_busy_n_o ##1 write_busy_n_o; endproperty
	a_busy: assert property (p_busy) else $error("busy width wrong");
	property p_int_stat; b_up && cmd_i == `DST_CMD_INTERP |-> (driving_status_out_o & axis_sel_i) == 0
		##1 (driving_status_out_o & axis_sel_i) == axis_sel_i; endproperty
	a_int_stat: assert property (p_int_stat) else $error("interp status late");
	property p_int_pls; b_up && cmd_i == `DST_CMD_INTERP |-> (pl & axis_sel_i) == 0 [*4]
		##1 (pl & axis_sel_i) != 0; endproperty
	a_int_pls: assert property (p_int_pls) else $error("interp pulse timing");
	property p_rel_stat; b_up && cmd_i == `DST_CMD_HOLD_REL |->
		(driving_status_out_o & ~$past(driving_status_out_o)) != 0; endproperty
	a_rel_stat: assert property (p_rel_stat) else $error("release status late");
	property p_rel_pls; b_up && cmd_i == `DST_CMD_HOLD_REL |-> ##1 pl == 0 [*2] ##1 pl != 0; endproperty
	a_rel_pls: assert property (p_rel_pls) else $error("release pulse timing");
	property p_dir; (|drive_pulse_out_o) && !two_pulse_i |-> $stable(direction_out_o)
		##1 $stable(direction_out_o); endproperty
	a_dir: assert property (p_dir) else $error("direction moved near pulse");
	property p_cap; cmd_i == `DST_CMD_INTERP && continuous_i && pl[0] |-> gap_r >= 8'h18; endproperty
	a_cap: assert property (p_cap) else $error("continuous rate too high");
	property p_max; pl[0] |-> gap_r >= 8'h0B; endproperty
	a_max: assert property (p_max) else $error("pulse rate too high");
	property p_stat_src; (driving_status_out_o & ~$past(driving_status_out_o)) != 0 |->
		!$past(write_busy_n_o) || !$past(write_busy_n_o, 2); endproperty
	a_stat_src: assert property (p_stat_src) else $error("status rose without command");
	c_int: cover property (b_up && cmd_i == `DST_CMD_INTERP);
	c_rel: cover property (b_up && cmd_i == `DST_CMD_HOLD_REL);
	c_cap: cover property (continuous_i && pl[0] && gap_r != 8'hFF);
endmodule // dst_chk
bind dst_top dst_chk #(.NUM_AXES(NUM_AXES)) chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_i(cmd_i),
	.axis_sel_i(axis_sel_i), .two_pulse_i(two_pulse_i), .continuous_i(continuous_i),
	.write_busy_n_o(write_busy_n_o), .plus_pulse_out_o(plus_pulse_out_o),
	.minus_pulse_out_o(minus_pulse_out_o), .drive_pulse_out_o(drive_pulse_out_o),
	.direction_out_o(direction_out_o), .driving_status_out_o(driving_status_out_o));

// *** verif/dst_motor_model.sv ***
// Motor driver model: counts pulses per axis on each pulse pin, 8 bits an axis.
// Assumes positive-logic pulses one core clock wide.
`timescale 1ns/1ps
module dst_motor_model (
	// Clock and clear
	input wire		core_clk_i,
	input wire		clr_i,
	// Pulse pins
	input wire [3:0]	plus_pulse_i,
	input wire [3:0]	minus_pulse_i,
	input wire [3:0]	drive_pulse_i,
	// Counts
	output reg [31:0]	plus_cnt_o,
	output reg [31:0]	minus_cnt_o,
	output reg [31:0]	drive_cnt_o
);
	integer i;
	always @(posedge core_clk_i)
		for (i = 0; i < 4; i = i + 1)
		begin
			plus_cnt_o[i*8 +: 8] <= clr_i ? 8'h00 : plus_cnt_o[i*8 +: 8] + {7'h00, plus_pulse_i[i]};
			minus_cnt_o[i*8 +: 8] <= clr_i ? 8'h00 : minus_cnt_o[i*8 +: 8] + {7'h00, minus_pulse_i[i]};
			drive_cnt_o[i*8 +: 8] <= clr_i ? 8'h00 : drive_cnt_o[i*8 +: 8] + {7'h00, drive_pulse_i[i]};
		end
endmodule // dst_motor_model

// *** verif/tb.sv ***
// Testbench for dst_top: interpolated and hold-release start latencies, hold release, profiles.
// Inputs change 1 ns after the rising clock edge.
`timescale 1ns/1ps
`include "dst_consts.vh"
`define CHK(a, b) begin samples_checked = samples_checked + 1; if ((a) !== (b)) begin \
	n_errors = n_errors + 1; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	reg		core_clk_i = 1'b0;
	reg		rst_i = 1'b1;
	reg		strb_n = 1'b1, two = 1'b0, cont = 1'b0, clr = 1'b1;
	reg [1:0]	cmd = 2'h0, prof = 2'h0;
	reg [3:0]	sel = 4'h0, dir = 4'h0;
	reg [23:0]	rate = 24'h400000;
	wire		busy_n;
	wire [3:0]	pp, pm, pd, dr, stat;
	wire [31:0]	pc, mc, dc;
	reg [3:0]	st [0:5];
	reg [3:0]	pl [0:5];
	reg [3:0]	dq;
	integer		n_errors = 0, samples_checked = 0, cyc = 0;
	initial forever #5 core_clk_i = ~core_clk_i;
	dst_top dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .write_strobe_n_i(strb_n), .cmd_i(cmd),
		.axis_sel_i(sel), .dir_i(dir), .two_pulse_i(two), .continuous_i(cont), .profile_i(prof),
		.rate_max_i(rate), .rate_init_i(24'h100000), .accel_i(24'h001000), .pulse_count_i(32'h00000005),
		.write_busy_n_o(busy_n), .plus_pulse_out_o(pp), .minus_pulse_out_o(pm), .drive_pulse_out_o(pd),
		.direction_out_o(dr), .driving_status_out_o(stat));
	dst_motor_model mdl_u (.core_clk_i(core_clk_i), .clr_i(clr), .plus_pulse_i(pp), .minus_pulse_i(pm),
		.drive_pulse_i(pd), .plus_cnt_o(pc), .minus_cnt_o(mc), .drive_cnt_o(dc));
	task tick(input integer n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	// Issue one command, time busy, record status and pulses from busy rise on, then wait idle
	task go(input [1:0] c, input [3:0] s, input [3:0] d, input tp, input ct, input [1:0] pf);
		integer k;
		begin
			cmd = c; sel = s; dir = d; two = tp; cont = ct; prof = pf; clr = 1'b1; strb_n = 1'b0;
			tick(2);
			strb_n = 1'b1;
			clr = 1'b0;
			k = 0;
			while (busy_n !== 1'b0 && k < 20) begin tick(1); k = k + 1; end
			k = 0;
			while (busy_n !== 1'b1 && k < 20) begin tick(1); k = k + 1; end
			`CHK(k, 2)
			for (k = 0; k < 6; k = k + 1) begin st[k] = stat & s; pl[k] = (pp | pm | pd) & s; tick(1); end
			dq = dr & s;
			k = 0;
			while ((stat & s) !== 4'h0 && k < 20000) begin tick(1); k = k + 1; end
			`CHK(stat & s, 4'h0)
			tick(4);
		end
	endtask
	task t_interp;
		begin
			go(`DST_CMD_INTERP, 4'h3, 4'h2, 1'b0, 1'b0, `DST_PROF_CONST);
			`CHK(st[0], 4'h0)
			`CHK(st[1], 4'h3)
			`CHK(pl[3], 4'h0)
			`CHK(|pl[4], 1'b1)
			`CHK(dq, 4'h2)
			rate = 24'hFFFFFF;
			go(`DST_CMD_INTERP, 4'h5, 4'h4, 1'b1, 1'b1, `DST_PROF_CONST);
			`CHK(pc[23:16], 8'h00)
			`CHK(mc[7:0], 8'h00)
			rate = 24'h400000;
		end
	endtask
	task t_hold;
		begin
			go(`DST_CMD_DRIVE, 4'hF, 4'h0, 1'b0, 1'b1, `DST_PROF_CONST);
			`CHK(pl[3], 4'h0)
			go(`DST_CMD_HOLD_REL, 4'hF, 4'h0, 1'b0, 1'b0, `DST_PROF_CONST);
			`CHK(st[0], 4'hF)
			`CHK(pl[2], 4'h0)
			`CHK(pl[3], 4'hF)
		end
	endtask
	task t_prof;
		integer p;
		for (p = 0; p < 3; p = p + 1)
		begin
			go(`DST_CMD_DRIVE, 4'hA, 4'h8, 1'b1, 1'b0, p[1:0]);
			`CHK(pc[15:8], 8'h05)
			`CHK(mc[31:24], 8'h05)
		end
	endtask
	task summarize;
		begin
			$display("errors=%0d checks=%0d", n_errors, samples_checked);
			if (n_errors == 0 && samples_checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	always @(posedge core_clk_i)
	begin
		cyc = cyc + 1;
		if (cyc == 60000)
		begin
			n_errors = n_errors + 1;
			summarize;
		end
	end
	initial
	begin
		tick(5);
		rst_i = 1'b0;
		`CHK({busy_n, stat, pp | pm | pd}, 9'h100)
		t_interp;
		t_hold;
		t_prof;
		summarize;
	end
endmodule // tb
